// ==== core/mcc_top.v ====
// Summary of operation
// RL1: Configure presets settings, trigger stays idle
// RL2: READ waits trigger, reading to output
// RL3: INIT waits trigger, reading to memory
// RL4: FETCH copies memory readings to output
// RL5: Over 512 readings at INIT: memory error
// RL6: After INIT refuse commands until done
// RL7: Bus trigger accepted during sequence
// RL8: Range MIN low, MAX high, DEF auto
// RL9: Resolution MIN fine, MAX coarse, DEF 10
// RL10: AC functions always measure six-and-half digits
// RL11: Measure presets and reads immediately
// RL12: Ratio reference always autoranged
// RL13: Frequency single range, zero without signal
// RL14: Period single range, zero without signal
// RL15: Continuity fixed one kilohm, five-half digits
// RL16: Diode fixed 1 V, 1 mA, five-half
// RL17: Config query returns function, range, resolution
// RL18: Stop measuring while output is full
// RL19: Measure equals configure then READ; MEAS goes straight to ST_MEAS with no trigger wait and no start pulse
// RL20: Return idle, then accept commands
`timescale 1ns/1ps
`include "mcc_map.vh"
module mcc_top #(
  parameter AW = 9
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        ext_trig_i,
  input  wire        signal_present_i,
  input  wire [31:0] adc_data_i,
  output reg         meas_start_o,
  input  wire        meas_done_i,
  output reg  [3:0]  meas_func_o,
  output reg  [3:0]  meas_range_o,
  output reg         meas_auto_o,
  output reg         ref_auto_o,
  output reg  [3:0]  meas_res_o,
  output reg  [3:0]  disp_res_o,
  output reg  [7:0]  power_line_cycles_o,
  output reg  [10:0] src_current_ua_o,
  output reg         wait_trig_o,
  output reg         mem_err_o
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_WAIT  = 3'd1;
  localparam ST_MEAS  = 3'd2;
  localparam ST_FETCH = 3'd3;
  localparam ST_FDRN  = 3'd4;
  localparam ST_NEXT  = 3'd5;

  reg [2:0]  state_ff, nxt_state;
  reg        to_mem_ff;
  reg        trig_src_bus_ff;
  reg [15:0] samp_cnt_ff;
  reg [15:0] trig_cnt_ff;
  reg [15:0] s_left_ff;
  reg [15:0] t_left_ff;
  reg [AW:0] wr_ptr_ff;
  reg [AW:0] rd_ptr_ff;
  reg [31:0] out_ff;
  reg        out_full_ff;
  reg        bus_trig_ff;
  reg        ph_valid_ff;
  reg        ph_write_ff;
  reg [7:0]  ph_addr_ff;
  reg [1:0]  ext_sync_ff;
  reg        ext_prev_ff;
  reg [1:0]  sig_sync_ff;
  reg        mem_we;
  wire [31:0] mem_rdata;
  wire        ext_pulse = ext_sync_ff[1] & ~ext_prev_ff;
  wire        busy = (state_ff != ST_IDLE);
  // Output word is owned by an unread reading; memory runs never block on it
  wire        out_blocked = out_full_ff & ~to_mem_ff;
  wire        wr_acc = ph_valid_ff & ph_write_ff;
  wire        rd_out = ph_valid_ff & ~ph_write_ff & (ph_addr_ff == `MCC_OUT_OFS);
  wire [31:0] total = samp_cnt_ff * trig_cnt_ff;
  wire [31:0] reading = (((meas_func_o == `MCC_FN_FREQ) || (meas_func_o == `MCC_FN_PER))
                        && !sig_sync_ff[1]) ? 32'h0000_0000 : adc_data_i;

  // Maps a range/resolution selector to a code
  function [3:0] arg_map;
    input [1:0] sel;
    input [3:0] val;
    input [3:0] lo;
    input [3:0] hi;
    begin
      case (sel)
        `MCC_ARG_MIN: arg_map = lo;
        `MCC_ARG_MAX: arg_map = hi;
        default:      arg_map = val;
      endcase
    end
  endfunction

  mcc_mem #(.DW(32), .AW(AW)) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (wr_ptr_ff[AW-1:0]),
    .wdata_i (reading),
    .raddr_i (rd_ptr_ff[AW-1:0]),
    .rdata_o (mem_rdata)
  );

  // Pin synchronisers; edge detect reads only the second stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync_ff <= 2'b00;
      ext_prev_ff <= 1'b0;
      sig_sync_ff <= 2'b00;
    end else begin
      ext_sync_ff <= {ext_sync_ff[0], ext_trig_i};
      ext_prev_ff <= ext_sync_ff[1];
      sig_sync_ff <= {sig_sync_ff[0], signal_present_i};
    end
  end

  // AHB-Lite address phase capture; always zero-wait, OKAY
  always @(posedge clk_i) begin
    if (rst_i) begin
      ph_valid_ff <= 1'b0;
      ph_write_ff <= 1'b0;
      ph_addr_ff  <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else if (hready) begin
      ph_valid_ff <= hsel & htrans[1];
      ph_write_ff <= hwrite;
      ph_addr_ff  <= haddr[7:0];
    end
  end

  // Read data is registered from the address phase
  always @(posedge clk_i) begin
    if (rst_i) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `MCC_COUNT_OFS:  hrdata <= {trig_cnt_ff, samp_cnt_ff};
        `MCC_STATUS_OFS: hrdata <= {24'h00_0000, 1'b0, state_ff, wait_trig_o, out_full_ff, mem_err_o, busy};
        `MCC_OUT_OFS:    hrdata <= out_ff;
        // Configuration query packs function, range, resolution [RL17]
        `MCC_QUERY_OFS:  hrdata <= {16'h0000, meas_auto_o, 3'b000, meas_res_o, meas_range_o, meas_func_o};
        `MCC_RDG_OFS:    hrdata <= {{(31-AW){1'b0}}, wr_ptr_ff};
        `MCC_CFG_OFS:    hrdata <= {{31{1'b0}}, trig_src_bus_ff};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Sequencer next state
  always @* begin
    nxt_state = state_ff;
    mem_we    = 1'b0;
    case (state_ff)
      // Idle is left only through a command in the clocked process
      ST_IDLE: nxt_state = ST_IDLE;
      ST_WAIT: begin
        // Bus or external trigger starts the reading [RL2] [RL3] [RL7]
        // A trigger that lands while the output word is unread is lost [RL18]
        if ((trig_src_bus_ff ? bus_trig_ff : ext_pulse) && !out_blocked) begin
          nxt_state = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (meas_done_i) begin
          mem_we = to_mem_ff; // [RL3]
          if ((s_left_ff <= 16'd1) && (t_left_ff <= 16'd1)) begin
            nxt_state = ST_IDLE; // [RL20]
          end else if (s_left_ff <= 16'd1) begin
            nxt_state = ST_WAIT;
          end else begin
            // Further samples of this trigger need no new trigger
            nxt_state = ST_NEXT;
          end
        end
      end
      // Next sample of the same trigger waits for the output word [RL18]
      ST_NEXT: begin
        if (!out_blocked) begin
          nxt_state = ST_MEAS;
        end
      end
      // Fetch drains memory one word at a time behind the output word
      ST_FETCH: begin
        if (rd_ptr_ff == wr_ptr_ff) begin
          nxt_state = ST_IDLE; // [RL20]
        end else if (!out_full_ff) begin
          nxt_state = ST_FDRN;
        end
      end
      ST_FDRN:  nxt_state = ST_FETCH;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  // Command decode, configuration and measurement control
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff            <= ST_IDLE;
      to_mem_ff           <= 1'b0;
      trig_src_bus_ff     <= 1'b0;
      samp_cnt_ff         <= 16'd1;
      trig_cnt_ff         <= 16'd1;
      s_left_ff           <= 16'd0;
      t_left_ff           <= 16'd0;
      wr_ptr_ff           <= {(AW+1){1'b0}};
      rd_ptr_ff           <= {(AW+1){1'b0}};
      out_ff              <= 32'h0000_0000;
      out_full_ff         <= 1'b0;
      bus_trig_ff         <= 1'b0;
      meas_start_o        <= 1'b0;
      meas_func_o         <= `MCC_FN_DCV;
      meas_range_o        <= `MCC_RNG_LOW;
      meas_auto_o         <= 1'b1;
      ref_auto_o          <= 1'b1;
      meas_res_o          <= `MCC_RES_5D;
      disp_res_o          <= `MCC_RES_5D;
      power_line_cycles_o <= `MCC_PLC_DEF;
      src_current_ua_o    <= 11'd0;
      wait_trig_o         <= 1'b0;
      mem_err_o           <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      bus_trig_ff  <= 1'b0;
      // Every reading except a measure command is opened by one start pulse
      meas_start_o <= ((state_ff == ST_WAIT) || (state_ff == ST_NEXT)) && (nxt_state == ST_MEAS);
      wait_trig_o  <= (nxt_state == ST_WAIT);
      // Host draining the output word frees it; a new reading wins
      if (rd_out) begin
        out_full_ff <= 1'b0;
      end
      if (state_ff == ST_MEAS && meas_done_i) begin
        if (to_mem_ff) begin
          wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end else begin
          out_ff      <= reading; // [RL2] [RL13] [RL14]
          out_full_ff <= 1'b1;
        end
        if (s_left_ff <= 16'd1) begin
          s_left_ff <= samp_cnt_ff;
          t_left_ff <= t_left_ff - 1'b1;
        end else begin
          s_left_ff <= s_left_ff - 1'b1;
        end
      end
      // Fetch moves one stored reading into the output word
      if (state_ff == ST_FDRN) begin
        out_ff      <= mem_rdata; // [RL4]
        out_full_ff <= 1'b1;
        rd_ptr_ff   <= rd_ptr_ff + 1'b1;
      end
      if (wr_acc && ph_addr_ff == `MCC_CFG_OFS && !busy) begin
        trig_src_bus_ff <= hwdata[0];
      end
      if (wr_acc && ph_addr_ff == `MCC_COUNT_OFS && !busy) begin
        samp_cnt_ff <= hwdata[15:0];
        trig_cnt_ff <= hwdata[31:16];
      end
      // Bus trigger is the one command honoured while busy [RL7]
      if (wr_acc && ph_addr_ff == `MCC_CMD_OFS && hwdata[3:0] == `MCC_OP_BUSTRIG) begin
        bus_trig_ff <= (state_ff == ST_WAIT) && trig_src_bus_ff;
      end
      // All other commands refused until back in idle [RL6] [RL20]
      if (wr_acc && ph_addr_ff == `MCC_CMD_OFS && !busy) begin
        if (hwdata[3:0] == `MCC_OP_CONF || hwdata[3:0] == `MCC_OP_MEAS) begin
          // Preset; trigger system stays idle on configure [RL1] [RL19]
          meas_func_o         <= hwdata[7:4];
          meas_range_o        <= arg_map(hwdata[9:8], hwdata[15:12], `MCC_RNG_LOW, `MCC_RNG_HIGH); // [RL8]
          meas_auto_o         <= (hwdata[9:8] == `MCC_ARG_DEF); // [RL8]
          ref_auto_o          <= 1'b1; // [RL12]
          meas_res_o          <= (hwdata[17:16] == `MCC_ARG_DEF) ? `MCC_RES_5D :
                                 arg_map(hwdata[17:16], hwdata[23:20], `MCC_RES_FINE, `MCC_RES_COARSE); // [RL9]
          disp_res_o          <= (hwdata[17:16] == `MCC_ARG_DEF) ? `MCC_RES_5D :
                                 arg_map(hwdata[17:16], hwdata[23:20], `MCC_RES_FINE, `MCC_RES_COARSE);
          power_line_cycles_o <= `MCC_PLC_DEF; // [RL9]
          src_current_ua_o    <= 11'd0;
          samp_cnt_ff         <= 16'd1;
          trig_cnt_ff         <= 16'd1;
          trig_src_bus_ff     <= 1'b0;
          case (hwdata[7:4])
            `MCC_FN_ACV, `MCC_FN_ACI: meas_res_o <= `MCC_RES_6D; // [RL10]
            `MCC_FN_FREQ, `MCC_FN_PER: begin
              meas_range_o <= `MCC_RNG_FIXED; // [RL13] [RL14]
              meas_auto_o  <= 1'b0;
            end
            `MCC_FN_CONT: begin
              meas_range_o <= `MCC_RNG_1K; // [RL15]
              meas_auto_o  <= 1'b0;
              meas_res_o   <= `MCC_RES_5D;
              disp_res_o   <= `MCC_RES_5D;
            end
            `MCC_FN_DIODE: begin
              meas_range_o     <= `MCC_RNG_1V; // [RL16]
              meas_auto_o      <= 1'b0;
              meas_res_o       <= `MCC_RES_5D;
              disp_res_o       <= `MCC_RES_5D;
              src_current_ua_o <= `MCC_DIODE_UA;
            end
            default: meas_auto_o <= (hwdata[9:8] == `MCC_ARG_DEF);
          endcase
          if (hwdata[3:0] == `MCC_OP_MEAS) begin
            // Measure runs at once with immediate trigger [RL11]
            state_ff  <= ST_MEAS;
            to_mem_ff <= 1'b0;
            s_left_ff <= 16'd1;
            t_left_ff <= 16'd1;
          end
        end else if (hwdata[3:0] == `MCC_OP_READ) begin
          state_ff  <= ST_WAIT; // [RL2]
          to_mem_ff <= 1'b0;
          s_left_ff <= samp_cnt_ff;
          t_left_ff <= trig_cnt_ff;
        end else if (hwdata[3:0] == `MCC_OP_INIT) begin
          if (total > `MCC_MEM_DEPTH) begin
            mem_err_o <= 1'b1; // [RL5]
          end else begin
            mem_err_o <= 1'b0;
            state_ff  <= ST_WAIT; // [RL3]
            to_mem_ff <= 1'b1;
            wr_ptr_ff <= {(AW+1){1'b0}};
            rd_ptr_ff <= {(AW+1){1'b0}};
            s_left_ff <= samp_cnt_ff;
            t_left_ff <= trig_cnt_ff;
          end
        end else if (hwdata[3:0] == `MCC_OP_FETCH) begin
          state_ff  <= ST_FETCH; // [RL4]
          rd_ptr_ff <= {(AW+1){1'b0}};
        end
      end
    end
  end
endmodule

// ==== core/mcc_map.vh ====
`ifndef MCC_MAP_VH
`define MCC_MAP_VH
// Register byte offsets
`define MCC_CMD_OFS      8'h00
`define MCC_CFG_OFS      8'h04
`define MCC_COUNT_OFS    8'h08
`define MCC_STATUS_OFS   8'h0C
`define MCC_OUT_OFS      8'h10
`define MCC_QUERY_OFS    8'h14
`define MCC_RDG_OFS      8'h18
// Command codes in CMD[3:0]
`define MCC_OP_CONF      4'h1
`define MCC_OP_READ      4'h2
`define MCC_OP_INIT      4'h3
`define MCC_OP_FETCH     4'h4
`define MCC_OP_MEAS      4'h5
`define MCC_OP_BUSTRIG   4'h6
// CMD field positions
`define MCC_CMD_FUNC_LSB 4
`define MCC_CMD_RSEL_LSB 8
`define MCC_CMD_RVAL_LSB 12
`define MCC_CMD_QSEL_LSB 16
`define MCC_CMD_QVAL_LSB 20
// Functions
`define MCC_FN_DCV       4'h0
`define MCC_FN_ACV       4'h1
`define MCC_FN_DCI       4'h2
`define MCC_FN_ACI       4'h3
`define MCC_FN_RES2      4'h4
`define MCC_FN_RES4      4'h5
`define MCC_FN_FREQ      4'h6
`define MCC_FN_PER       4'h7
`define MCC_FN_CONT      4'h8
`define MCC_FN_DIODE     4'h9
`define MCC_FN_RATIO     4'hA
// Argument selectors
`define MCC_ARG_VAL      2'd0
`define MCC_ARG_MIN      2'd1
`define MCC_ARG_MAX      2'd2
`define MCC_ARG_DEF      2'd3
// Range and resolution codes, default line cycles, memory depth and diode current
`define MCC_RNG_LOW      4'h0
`define MCC_RNG_HIGH     4'h4
`define MCC_RNG_1K       4'h1
`define MCC_RNG_1V       4'h1
`define MCC_RNG_FIXED    4'h0
`define MCC_RES_FINE     4'h0
`define MCC_RES_COARSE   4'h4
`define MCC_RES_5D       4'h2
`define MCC_RES_6D       4'h0
`define MCC_PLC_DEF      8'd10
`define MCC_MEM_DEPTH    512
`define MCC_DIODE_UA     11'd1000
`endif

// ==== core/mcc_mem.v ====
`timescale 1ns/1ps
// Reading memory, flip-flop storage addressed by index
module mcc_mem #(
  parameter DW = 32,
  parameter AW = 9
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire [AW-1:0] raddr_i,
  output wire [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_ff [0:(1<<AW)-1];

  // Write port only; contents need no reset
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem_ff[raddr_i];
endmodule

// ==== bench/mcc_top_monitor.sv ====
`timescale 1ns/1ps
`include "mcc_map.vh"
// Setting and sequencing checks, seen from the top ports only
module mcc_top_monitor (
  input wire        clk_i,
  input wire        rst_i,
  input wire        meas_start_o,
  input wire [3:0]  meas_func_o,
  input wire [3:0]  meas_range_o,
  input wire [3:0]  meas_res_o,
  input wire        ref_auto_o,
  input wire [10:0] src_current_ua_o,
  input wire        wait_trig_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Function decodes for the AC resolution and single-range checks
  wire is_ac = (meas_func_o == `MCC_FN_ACV) || (meas_func_o == `MCC_FN_ACI);
  wire is_fp = (meas_func_o == `MCC_FN_FREQ) || (meas_func_o == `MCC_FN_PER);

  a_cont_fixed: assert property (
    meas_func_o == `MCC_FN_CONT |-> meas_range_o == `MCC_RNG_1K && meas_res_o == `MCC_RES_5D)
    else $error("continuity setting wrong");
  a_diode_range: assert property (
    meas_func_o == `MCC_FN_DIODE |-> meas_range_o == `MCC_RNG_1V && meas_res_o == `MCC_RES_5D)
    else $error("diode setting wrong");
  a_diode_source: assert property (
    meas_func_o == `MCC_FN_DIODE |-> src_current_ua_o == `MCC_DIODE_UA)
    else $error("diode source wrong");
  a_ac_six_digit: assert property (is_ac |-> meas_res_o == `MCC_RES_6D)
    else $error("ac resolution wrong");
  a_ratio_ref_auto: assert property (meas_func_o == `MCC_FN_RATIO |-> ref_auto_o)
    else $error("ratio reference not autoranged");
  a_single_range: assert property (is_fp |-> meas_range_o == `MCC_RNG_FIXED)
    else $error("frequency range wrong");
  a_start_pulse: assert property (meas_start_o |=> !meas_start_o)
    else $error("start longer than one cycle");
  a_start_armed: assert property ($fell(wait_trig_o) |-> meas_start_o)
    else $error("wait left without a start");
  a_conf_idle: assert property ($changed(meas_func_o) |-> !wait_trig_o && !meas_start_o)
    else $error("preset while not idle");
  cover property (wait_trig_o ##[1:200] meas_start_o);
  cover property (meas_func_o == `MCC_FN_DIODE);
  cover property ($fell(wait_trig_o));
endmodule

// ==== bench/mcc_meas_model.sv ====
`timescale 1ns/1ps
// Measurement front end: answers a start after a chosen delay
module mcc_meas_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        kick_i,
  input  wire [2:0]  dly_i,
  output reg         done_o,
  output reg  [31:0] data_o
);
  reg [3:0]  cnt_ff;
  reg [31:0] val_ff;
  // Data only valid with done; inverted every cycle otherwise, so a stale value returns on alternate cycles
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i) begin
      cnt_ff <= 4'h0;
      val_ff <= 32'h0000_1234;
      data_o <= 32'h0000_0000;
    end else if (start_i || kick_i) begin
      cnt_ff <= {1'b0, dly_i} + 4'h1;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h1) begin
        done_o <= 1'b1;
        data_o <= val_ff;
        val_ff <= {val_ff[30:0], val_ff[31] ^ val_ff[21] ^ val_ff[1] ^ val_ff[0]};
      end
    end
  end
endmodule

// ==== bench/tb_measurement_config_command_handler.sv ====
`timescale 1ns/1ps
`include "mcc_map.vh"
module tb_measurement_config_command_handler;
  reg         clk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, trig = 0, kick = 0, sig = 1;
  reg  [31:0] haddr = 0, hwdata = 0, seed = 32'h1954, q, ns = 0, ns0;
  reg  [1:0]  htrans = 0;
  reg  [2:0]  hsize = 3'b010, dly = 0, nd = 0;
  reg  [31:0] rq [0:7];
  wire [31:0] hrdata, adc;
  wire [3:0]  fn, rng, res, dres;
  wire [10:0] src;
  wire [7:0]  power_line_cycles;
  wire        rdy, resp, start, done, aut, rauto, wt, merr;
  integer     err_count = 0, cmp_count = 0, cyc = 0, i;
  reg  [1:0]  rs, qs;
  reg         ea;
  always #2.5 clk_i = ~clk_i;
  mcc_top mcc_top_i (.clk_i(clk_i), .rst_i(rst_i), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(resp),
    .ext_trig_i(trig), .signal_present_i(sig), .adc_data_i(adc), .meas_start_o(start), .meas_done_i(done),
    .meas_func_o(fn), .meas_range_o(rng), .meas_auto_o(aut), .ref_auto_o(rauto), .meas_res_o(res),
    .disp_res_o(dres), .power_line_cycles_o(power_line_cycles), .src_current_ua_o(src), .wait_trig_o(wt), .mem_err_o(merr));
  mcc_meas_model mcc_meas_model_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .kick_i(kick), .dly_i(dly),
    .done_o(done), .data_o(adc));
  // Log readings and starts; timeout well above the expected run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (done) begin
      rq[nd] <= adc;
      nd <= nd + 3'd1;
    end
    if (start) ns <= ns + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [31:0] cmdw(input [3:0] op, input [3:0] f, input [1:0] r, input [1:0] s);
    cmdw = {8'h00, 6'h00, s, 6'h00, r, f, op};
  endfunction
  // Expected range and resolution, 4'hf where the setting is left open
  function [7:0] exp_set(input [3:0] f, input [1:0] r, input [1:0] s);
    reg [3:0] er, es;
    begin
      er = (r == `MCC_ARG_MIN) ? `MCC_RNG_LOW : (r == `MCC_ARG_MAX) ? `MCC_RNG_HIGH : 4'hf;
      es = (s == `MCC_ARG_MIN) ? `MCC_RES_FINE : (s == `MCC_ARG_MAX) ? `MCC_RES_COARSE : `MCC_RES_5D;
      if (f == `MCC_FN_ACV || f == `MCC_FN_ACI) es = `MCC_RES_6D;
      if (f == `MCC_FN_FREQ || f == `MCC_FN_PER) {er, es} = {`MCC_RNG_FIXED, 4'hf};
      if (f == `MCC_FN_CONT) {er, es} = {`MCC_RNG_1K, `MCC_RES_5D};
      if (f == `MCC_FN_DIODE) {er, es} = {`MCC_RNG_1V, `MCC_RES_5D};
      exp_set = {er, es};
    end
  endfunction
  // Shown resolution follows the argument except where it is fixed
  function [3:0] exp_disp(input [3:0] f, input [1:0] s);
    exp_disp = (f == `MCC_FN_CONT || f == `MCC_FN_DIODE || s == `MCC_ARG_DEF) ? `MCC_RES_5D :
               (s == `MCC_ARG_MIN) ? `MCC_RES_FINE : `MCC_RES_COARSE;
  endfunction
  task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // One single AHB transfer; q takes the data at the closing edge
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk_i);
      while (rdy !== 1'b1) @(posedge clk_i);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk_i);
      while (rdy !== 1'b1) @(posedge clk_i);
      q = hrdata;
    end
  endtask
  // Poll the status word until the selected bit reads the wanted value
  task poll(input integer b, input v);
    integer n;
    begin
      n = 0;
      bus(0, `MCC_STATUS_OFS, 0);
      while (q[b] !== v && n < 300) begin
        bus(0, `MCC_STATUS_OFS, 0);
        n = n + 1;
      end
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("plc", power_line_cycles, `MCC_PLC_DEF);
    // Every function with random argument selectors
    for (i = 0; i < 11; i = i + 1) begin
      seed = xs(seed);
      rs = seed % 3 + 1;
      qs = seed[9:8] % 3 + 1;
      dly <= seed[14:12];
      bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_CONF, i[3:0], rs, qs));
      poll(0, 0);
      ea = (rs == `MCC_ARG_DEF) && (i < 6 || i == `MCC_FN_RATIO);
      chk("func", fn, i);
      if (exp_set(i, rs, qs) >> 4 != 4'hf) chk("range", rng, exp_set(i, rs, qs) >> 4);
      if (exp_set(i, rs, qs) % 16 != 4'hf) chk("res", res, exp_set(i, rs, qs) % 16);
      chk("auto", aut, ea);
      chk("disp", dres, exp_disp(i[3:0], qs));
      bus(0, `MCC_QUERY_OFS, 0);
      chk("query", {q[15], q[3:0]}, {ea, i[3:0]});
      chk("wait", wt, 0);
    end
    chk("starts", ns, 0);
    // Two readings per trigger while the output word is left unread
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_CONF, `MCC_FN_DCV, `MCC_ARG_DEF, `MCC_ARG_DEF));
    chk("plc", power_line_cycles, `MCC_PLC_DEF);
    bus(1, `MCC_COUNT_OFS, 32'h0001_0002);
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_READ, 0, 0, 0));
    repeat (2) @(posedge clk_i);
    chk("wait", wt, 1);
    ns0 = ns;
    trig <= 1'b1;
    repeat (4) @(posedge clk_i);
    trig <= 1'b0;
    poll(2, 1);
    repeat (40) @(posedge clk_i);
    chk("starts", ns - ns0, 1);
    bus(0, `MCC_OUT_OFS, 0);
    chk("out", q, rq[nd - 3'd1]);
    poll(2, 1);
    bus(0, `MCC_OUT_OFS, 0);
    chk("out", q, rq[nd - 3'd1]);
    poll(0, 0);
    chk("wait", wt, 0);
    // Stored reading by bus trigger, with a command refused meanwhile
    bus(1, `MCC_CFG_OFS, 1);
    bus(1, `MCC_COUNT_OFS, 32'h0001_0001);
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_INIT, 0, 0, 0));
    repeat (2) @(posedge clk_i);
    chk("wait", wt, 1);
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_CONF, `MCC_FN_DIODE, 0, 0));
    chk("func", fn, `MCC_FN_DCV);
    chk("resp", resp, 0);
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_BUSTRIG, 0, 0, 0));
    poll(0, 0);
    bus(0, `MCC_RDG_OFS, 0);
    chk("stored", q, 1);
    bus(0, `MCC_STATUS_OFS, 0);
    chk("full", q[2], 0);
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_FETCH, 0, 0, 0));
    poll(2, 1);
    bus(0, `MCC_OUT_OFS, 0);
    chk("fetch", q, rq[nd - 3'd1]);
    // Measure frequency with no signal: zero reading, no trigger needed
    poll(0, 0);
    sig <= 1'b0;
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_MEAS, `MCC_FN_FREQ, `MCC_ARG_MIN, `MCC_ARG_MIN));
    kick <= 1'b1;
    @(posedge clk_i);
    kick <= 1'b0;
    poll(2, 1);
    bus(0, `MCC_OUT_OFS, 0);
    chk("meas", q, 0);
    chk("func", fn, `MCC_FN_FREQ);
    // Sample count times trigger count of 514 overflows memory
    poll(0, 0);
    bus(1, `MCC_COUNT_OFS, 32'h0002_0101);
    bus(1, `MCC_CMD_OFS, cmdw(`MCC_OP_INIT, 0, 0, 0));
    repeat (2) @(posedge clk_i);
    chk("memerr", merr, 1);
    test_done;
  end
endmodule
bind mcc_top mcc_top_monitor mcc_top_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .meas_start_o(meas_start_o),
  .meas_func_o(meas_func_o), .meas_range_o(meas_range_o), .meas_res_o(meas_res_o), .ref_auto_o(ref_auto_o),
  .src_current_ua_o(src_current_ua_o), .wait_trig_o(wait_trig_o));
